// ===== rtl/gbc_pkg.sv
// constants for the bus-command handler of the instrument port
package gbc_pkg;

   // *************************************************************
   // register offsets (word index on the plain register port)
   // *************************************************************
   localparam logic [3:0] OFS_CTRL     = 4'h0;
   localparam logic [3:0] OFS_SVC      = 4'h1;
   localparam logic [3:0] OFS_STATE    = 4'h2;
   localparam logic [3:0] OFS_SETTINGS = 4'h3;
   localparam logic [3:0] OFS_BUF_PTR  = 4'h4;
   localparam logic [3:0] OFS_EVENTS   = 4'h5;
   localparam logic [3:0] OFS_RX       = 4'h6;
   localparam logic [3:0] OFS_TX       = 4'h7;

   // *************************************************************
   // control register fields
   // *************************************************************
   localparam int CTRL_ADDR_LSB = 0;
   localparam int CTRL_EOI_BIT  = 5;
   localparam int CTRL_SRQ_BIT  = 6;

   // *************************************************************
   // settings register fields
   // *************************************************************
   localparam int SET_DISP_LSB = 0;
   localparam int SET_FUNC_LSB = 4;
   localparam int SET_FMT_LSB  = 8;
   localparam int SET_TERM_LSB = 12;

   // *************************************************************
   // events register bits, status byte request bit
   // *************************************************************
   localparam int EV_CLEAR_BIT = 0;
   localparam int EV_IFC_BIT   = 1;
   localparam int EV_RXOV_BIT  = 2;
   localparam int RQS_BIT      = 6;

   // *************************************************************
   // reset and clear defaults
   // *************************************************************
   localparam logic [4:0]  RST_ADDR    = 5'h0a;
   localparam logic        RST_EOI_EN  = 1'b1;
   localparam logic        RST_SRQ_EN  = 1'b0;
   localparam logic [7:0]  RST_STATUS  = 8'h00;
   localparam logic [3:0]  display_volts_amps_default = 4'h0;
   localparam logic [3:0]  standby_function_default   = 4'h0;
   localparam logic [3:0]  prefixed_output_format     = 4'h0;
   localparam logic [3:0]  TERM_CR_LF                 = 4'h0;
   localparam logic [7:0]  FIRST_LOCATION             = 8'h01;
   localparam logic [15:0] STANDBY_COUNTS             = 16'h0004;

   // *************************************************************
   // bus command bytes (logical value, seven bits) and two-bit command groups
   // *************************************************************
   localparam logic [6:0] CMD_DCL = 7'h14;
   localparam logic [6:0] CMD_SPE = 7'h18;
   localparam logic [6:0] CMD_SPD = 7'h19;
   localparam logic [6:0] CMD_UNL = 7'h3f;
   localparam logic [6:0] CMD_UNT = 7'h5f;
   localparam logic [1:0] GRP_LISTEN = 2'b01;
   localparam logic [1:0] GRP_TALK   = 2'b10;

endpackage

// ===== rtl/gbc_top.sv
// bus-command handler: uniline lines, universal commands, serial poll
//
// Operation
// - atn low marks command bytes; atn high marks device data
// - commands acted on with atn low; data only with atn high and addressed
// - ren asserted puts device in remote and lights remote indicator
// - eoi marks last byte; honoured only in matching response mode
// - ifc drops talk and listen states, keeps remote unchanged
// - srq pulled low for service only when srq mode enabled
// - device clear with atn low restores power-up defaults of settings, eoi and srq modes and buffer pointer only
// - device clear sets buffer pointer to location one
// - device clear leaves stored per-location parameters untouched
// - polled talker with atn released drives status byte on data lines
// - status byte is all zero after power-up
// - spd ends serial poll and stops presenting status byte
// - untalk leaves talker-addressed state
// - clear sets display to volts left, amps right, left editable
// - clear sets function to standby, output at plus four counts
// - clear sets data format to prefixed output
// - clear reloads sink, modulation, volts, amps, dwell from location
// - clear sets terminator to carriage return then line feed
`timescale 1ns/1ns
module gbc_top (
   // clock and reset
   input  wire logic        sys_clk,
   input  wire logic        reset_n,
   // register port
   input  wire logic [3:0]  reg_addr,
   input  wire logic [15:0] reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic      [15:0] reg_rdata,
   // bus management lines, low true
   input  wire logic        atn_n,
   input  wire logic        ren_n,
   input  wire logic        ifc_n,
   input  wire logic        eoi_n_in,
   output logic             eoi_n_out,
   output logic             eoi_oe,
   output logic             srq_n_out,
   output logic             srq_oe,
   // data lines, low true, with accepted-byte strobe from handshake
   input  wire logic [7:0]  dio_n_in,
   output logic      [7:0]  dio_n_out,
   output logic             dio_oe,
   input  wire logic        byte_strb,
   // indicators and instrument side
   output logic             remote_led,
   output logic             talk_led,
   output logic             listen_led,
   output logic             recall_pulse,
   output logic      [7:0]  recall_loc,
   output logic      [15:0] standby_level
);

   // *************************************************************
   // state
   // *************************************************************
   typedef struct packed {
      logic [4:0]  addr;
      logic        eoi_en;
      logic        srq_en;
      logic [7:0]  svc;
      logic        remote;
      logic        talk;
      logic        listen;
      logic        spoll;
      logic [3:0]  disp;
      logic [3:0]  func;
      logic [3:0]  fmt;
      logic [3:0]  term;
      logic [7:0]  buf_ptr;
      logic [2:0]  events;
      logic [7:0]  rx_byte;
      logic        rx_full;
      logic        rx_end;
      logic [7:0]  tx_byte;
      logic        tx_full;
      logic        tx_last;
      logic        recall;
      logic [15:0] rdata;
   } gbc_state_t;

   gbc_state_t st;
   gbc_state_t next_st;
   logic [1:0] rst_sync;
   logic       rst_n;

   // *************************************************************
   // reset release
   // *************************************************************
   // asserted at once, released on an edge so no flop leaves reset early
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         rst_sync <= 2'b00;
      end else begin
         rst_sync <= {rst_sync[0], 1'b1};
      end
   end
   assign rst_n = rst_sync[1];

   // *************************************************************
   // decode of bus inputs
   // *************************************************************
   logic       atn;
   logic [6:0] cmd;
   logic [7:0] dbyte;
   logic       cmd_strb;
   logic       data_strb;
   logic [7:0] status_byte;
   logic       srq_need;
   logic       wr_ctrl;
   logic       wr_svc;
   logic       wr_set;
   logic       wr_ptr;
   logic       wr_ev;
   logic       wr_tx;
   logic       rd_rx;

   assign atn       = ~atn_n;
   assign dbyte     = ~dio_n_in;
   assign cmd       = dbyte[6:0];
   assign cmd_strb  = byte_strb & atn;
   assign data_strb = byte_strb & ~atn;
   assign srq_need  = st.srq_en & (|st.svc);
   // request bit is computed, never stored, so it always tracks srq
   assign status_byte = (st.svc & ~(8'h01 << gbc_pkg::RQS_BIT)) |
                        ({7'h00, srq_need} << gbc_pkg::RQS_BIT);

   // *************************************************************
   // register port decode
   // *************************************************************
   assign wr_ctrl = reg_wr & (reg_addr == gbc_pkg::OFS_CTRL);
   assign wr_svc  = reg_wr & (reg_addr == gbc_pkg::OFS_SVC);
   assign wr_set  = reg_wr & (reg_addr == gbc_pkg::OFS_SETTINGS);
   assign wr_ptr  = reg_wr & (reg_addr == gbc_pkg::OFS_BUF_PTR);
   assign wr_ev   = reg_wr & (reg_addr == gbc_pkg::OFS_EVENTS);
   assign wr_tx   = reg_wr & (reg_addr == gbc_pkg::OFS_TX);
   assign rd_rx   = reg_rd & (reg_addr == gbc_pkg::OFS_RX);

   // *************************************************************
   // next state
   // *************************************************************
   always_comb begin
      next_st = st;
      next_st.recall = 1'b0;

      // *********************************************************
      // register writes
      // *********************************************************
      // software writes first, bus events below take priority
      if (wr_ctrl) begin
         next_st.addr   = reg_wdata[gbc_pkg::CTRL_ADDR_LSB +: 5];
         next_st.eoi_en = reg_wdata[gbc_pkg::CTRL_EOI_BIT];
         next_st.srq_en = reg_wdata[gbc_pkg::CTRL_SRQ_BIT];
      end
      if (wr_svc) begin
         next_st.svc = reg_wdata[7:0];
      end
      if (wr_set) begin
         next_st.disp = reg_wdata[gbc_pkg::SET_DISP_LSB +: 4];
         next_st.func = reg_wdata[gbc_pkg::SET_FUNC_LSB +: 4];
         next_st.fmt  = reg_wdata[gbc_pkg::SET_FMT_LSB +: 4];
         next_st.term = reg_wdata[gbc_pkg::SET_TERM_LSB +: 4];
      end
      if (wr_ptr) begin
         next_st.buf_ptr = reg_wdata[7:0];
      end
      if (wr_ev) begin
         // write one to clear; a new event this cycle still sets below
         next_st.events = st.events & ~reg_wdata[2:0];
      end
      if (wr_tx) begin
         next_st.tx_byte = reg_wdata[7:0];
         next_st.tx_last = reg_wdata[8];
         next_st.tx_full = 1'b1;
      end
      if (rd_rx) begin
         next_st.rx_full = 1'b0;
      end

      // *********************************************************
      // bus lines and commands, atn low
      // *********************************************************
      // plain level: local lockout is not kept here
      next_st.remote = ~ren_n;
      // universal and addressed commands only with atn low
      if (cmd_strb) begin
         if (cmd == gbc_pkg::CMD_DCL) begin
            // settings memory lives outside; only a recall is issued
            next_st.disp    = gbc_pkg::display_volts_amps_default;
            next_st.func    = gbc_pkg::standby_function_default;
            next_st.fmt     = gbc_pkg::prefixed_output_format;
            next_st.term    = gbc_pkg::TERM_CR_LF;
            next_st.eoi_en  = gbc_pkg::RST_EOI_EN;
            next_st.srq_en  = gbc_pkg::RST_SRQ_EN;
            next_st.buf_ptr = gbc_pkg::FIRST_LOCATION;
            next_st.recall  = 1'b1;
            next_st.events[gbc_pkg::EV_CLEAR_BIT] = 1'b1;
         end
         if (cmd == gbc_pkg::CMD_SPE) begin
            next_st.spoll = 1'b1;
         end
         if (cmd == gbc_pkg::CMD_SPD) begin
            next_st.spoll = 1'b0;
         end
         if (cmd[6:5] == gbc_pkg::GRP_TALK) begin
            // own talk address sets talk; any other clears it, and untalk
            // is compared explicitly so it clears talk even with address 31
            next_st.talk = (cmd[4:0] == st.addr) &
                           (cmd != gbc_pkg::CMD_UNT);
            if (cmd[4:0] == st.addr) begin
               next_st.listen = 1'b0;
            end
         end
         if (cmd[6:5] == gbc_pkg::GRP_LISTEN) begin
            if (cmd == gbc_pkg::CMD_UNL) begin
               next_st.listen = 1'b0;
            end else if (cmd[4:0] == st.addr) begin
               next_st.listen = 1'b1;
               next_st.talk   = 1'b0;
            end
         end
      end

      // *********************************************************
      // device data, atn high
      // *********************************************************
      // device data only with atn high and addressed to listen
      if (data_strb && st.listen) begin
         // unread byte lost: flag it and keep the newest
         if (st.rx_full && !rd_rx) begin
            next_st.events[gbc_pkg::EV_RXOV_BIT] = 1'b1;
         end
         next_st.rx_byte = dbyte;
         next_st.rx_full = 1'b1;
         next_st.rx_end  = ~eoi_n_in & st.eoi_en;
      end
      // our talker byte accepted by all listeners
      if (data_strb && st.talk && !st.spoll) begin
         next_st.tx_full = 1'b0;
      end

      // *********************************************************
      // interface clear, last so it overrides any address command
      // *********************************************************
      if (!ifc_n) begin
         next_st.talk   = 1'b0;
         next_st.listen = 1'b0;
         next_st.events[gbc_pkg::EV_IFC_BIT] = 1'b1;
      end

      // *********************************************************
      // read data, standing in the cycle after the strobe only
      // *********************************************************
      next_st.rdata = 16'h0000;
      if (reg_rd) begin
         case (reg_addr)
            gbc_pkg::OFS_CTRL:
               next_st.rdata = {9'h000, st.srq_en, st.eoi_en, st.addr};
            gbc_pkg::OFS_SVC:
               next_st.rdata = {8'h00, status_byte};
            gbc_pkg::OFS_STATE:
               next_st.rdata = {10'h000, st.tx_full, srq_need, st.spoll,
                                st.listen, st.talk, st.remote};
            gbc_pkg::OFS_SETTINGS:
               next_st.rdata = {st.term, st.fmt, st.func, st.disp};
            gbc_pkg::OFS_BUF_PTR:
               next_st.rdata = {8'h00, st.buf_ptr};
            gbc_pkg::OFS_EVENTS:
               next_st.rdata = {13'h0000, st.events};
            gbc_pkg::OFS_RX:
               next_st.rdata = {6'h00, st.rx_end, st.rx_full, st.rx_byte};
            gbc_pkg::OFS_TX:
               next_st.rdata = {7'h00, st.tx_last, st.tx_byte};
            default:
               next_st.rdata = 16'h0000;
         endcase
      end
   end

   // *************************************************************
   // state register
   // *************************************************************
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         st         <= '0;
         st.addr    <= gbc_pkg::RST_ADDR;
         st.eoi_en  <= gbc_pkg::RST_EOI_EN;
         st.srq_en  <= gbc_pkg::RST_SRQ_EN;
         st.svc     <= gbc_pkg::RST_STATUS;
         st.disp    <= gbc_pkg::display_volts_amps_default;
         st.func    <= gbc_pkg::standby_function_default;
         st.fmt     <= gbc_pkg::prefixed_output_format;
         st.term    <= gbc_pkg::TERM_CR_LF;
         st.buf_ptr <= gbc_pkg::FIRST_LOCATION;
      end else begin
         st <= next_st;
      end
   end

   // *************************************************************
   // outputs
   // *************************************************************
   logic talking;
   assign talking = st.talk & ~atn;

   always_comb begin
      // polled status wins over queued device data
      dio_n_out = 8'hff;
      dio_oe    = 1'b0;
      if (talking && st.spoll) begin
         dio_n_out = ~status_byte;
         dio_oe    = 1'b1;
      end else if (talking && st.tx_full) begin
         dio_n_out = ~st.tx_byte;
         dio_oe    = 1'b1;
      end
   end

   // *************************************************************
   // management lines
   // *************************************************************
   // open drain: only ever pulled low, released otherwise
   assign srq_n_out = 1'b0;
   assign srq_oe    = srq_need;
   assign eoi_n_out = 1'b0;
   assign eoi_oe    = talking & ~st.spoll & st.tx_full &
                      st.tx_last & st.eoi_en;

   // *************************************************************
   // register port and indicators
   // *************************************************************
   assign reg_rdata     = st.rdata;
   assign remote_led    = st.remote;
   assign talk_led      = st.talk;
   assign listen_led    = st.listen;
   assign recall_pulse  = st.recall;
   assign recall_loc    = st.buf_ptr;
   // level only; scaling to the present range is left to the source
   assign standby_level = (st.func == gbc_pkg::standby_function_default) ?
                          gbc_pkg::STANDBY_COUNTS : 16'h0000;

endmodule

// ===== sim/gbc_ctl_model.sv
// bus controller model for the handler's bus side
`timescale 1ns/1ns
module gbc_ctl_model (
   // clock
   input  wire logic       sys_clk,
   // lines toward the device
   output logic            atn_n,
   output logic            ren_n,
   output logic            ifc_n,
   output logic            eoi_n,
   output logic      [7:0] dio_drv_n,
   output logic            dio_en,
   output logic            byte_strb,
   // wired bus level
   input  wire logic [7:0] dio_bus_n
);
   // ***
   // line tasks
   // ***
   initial begin
      {atn_n, ren_n, ifc_n, eoi_n, dio_en, byte_strb} = 6'h3c;
      dio_drv_n = 8'hff;
   end
   // one byte per call; atn left as set so polls keep attention low
   task automatic send(input logic c, input logic [7:0] b, input logic e);
      @(posedge sys_clk);
      atn_n     <= ~c;
      eoi_n     <= ~e;
      dio_drv_n <= ~b;
      dio_en    <= 1'b1;
      byte_strb <= 1'b1;
      @(posedge sys_clk);
      byte_strb <= 1'b0;
      dio_en    <= 1'b0;
      eoi_n     <= 1'b1;
   endtask
   // released lines float to the pull-up level
   task automatic talk_read(output logic [7:0] b);
      @(posedge sys_clk);
      atn_n <= 1'b1;
      @(posedge sys_clk);
      b = ~dio_bus_n;
   endtask
   task automatic ifc_pulse;
      @(posedge sys_clk);
      ifc_n <= 1'b0;
      @(posedge sys_clk);
      ifc_n <= 1'b1;
   endtask
   task automatic set_ren(input logic v);
      @(posedge sys_clk);
      ren_n <= v;
   endtask
endmodule

// ===== sim/gbc_top_properties.sv
// port assertions for the bus-command handler
`timescale 1ns/1ns
module gbc_top_properties (
   // clock and reset
   input wire logic        sys_clk,
   input wire logic        reset_n,
   // bus side
   input wire logic        atn_n,
   input wire logic        ren_n,
   input wire logic        ifc_n,
   input wire logic [7:0]  dio_n_in,
   input wire logic        byte_strb,
   input wire logic        dio_oe,
   input wire logic [7:0]  dio_n_out,
   input wire logic        eoi_oe,
   input wire logic        srq_oe,
   // indicators and instrument side
   input wire logic        remote_led,
   input wire logic        talk_led,
   input wire logic        listen_led,
   input wire logic        recall_pulse,
   input wire logic [7:0]  recall_loc,
   input wire logic [15:0] standby_level
);
   // ***
   // helpers
   // ***
   logic [1:0] up_cnt;
   logic       ready;
   logic       cmd;
   logic [6:0] cb;
   logic       polled;
   assign ready = (up_cnt == 2'h3);
   assign cmd   = ready & byte_strb & ~atn_n;
   assign cb    = ~dio_n_in[6:0];
   // core sits in its synchroniser for two edges after release
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) up_cnt <= 2'h0;
      else if (!ready) up_cnt <= up_cnt + 2'h1;
   end
   // poll state mirrored from the command bytes seen on the bus
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) polled <= 1'b0;
      else if (cmd && cb == gbc_pkg::CMD_SPE) polled <= 1'b1;
      else if (cmd && cb == gbc_pkg::CMD_SPD) polled <= 1'b0;
   end
   default clocking dc @(posedge sys_clk); endclocking
   default disable iff (!reset_n);
   // ***
   // properties
   // ***
   property p_remote_on;
      ready && !ren_n |=> remote_led;
   endproperty
   a_remote_on: assert property (p_remote_on) else $error("remote off");
   property p_ifc;
      ready && !ifc_n && !ren_n |=> !talk_led && !listen_led && remote_led;
   endproperty
   a_ifc: assert property (p_ifc) else $error("ifc state wrong");
   property p_dcl;
      cmd && cb == gbc_pkg::CMD_DCL |=> recall_pulse && !srq_oe &&
         recall_loc == gbc_pkg::FIRST_LOCATION &&
         standby_level == gbc_pkg::STANDBY_COUNTS;
   endproperty
   a_dcl: assert property (p_dcl) else $error("clear incomplete");
   property p_no_clear;
      !(cmd && cb == gbc_pkg::CMD_DCL) |=> !recall_pulse;
   endproperty
   a_no_clear: assert property (p_no_clear) else $error("stray clear");
   property p_poll_drive;
      polled && talk_led && atn_n |-> dio_oe && (dio_n_out[6] == !srq_oe);
   endproperty
   a_poll_drive: assert property (p_poll_drive) else $error("no byte");
   property p_untalk;
      cmd && cb == gbc_pkg::CMD_UNT |=> !talk_led;
   endproperty
   a_untalk: assert property (p_untalk) else $error("still talker");
   property p_unlisten;
      cmd && cb == gbc_pkg::CMD_UNL |=> !listen_led;
   endproperty
   a_unlisten: assert property (p_unlisten) else $error("listen kept");
   property p_eoi;
      eoi_oe |-> dio_oe;
   endproperty
   a_eoi: assert property (p_eoi) else $error("eoi without byte");
   c_dcl: cover property (cmd && cb == gbc_pkg::CMD_DCL);
   c_poll: cover property (dio_oe && !eoi_oe);
   c_ifc: cover property (!ifc_n && talk_led);
endmodule
bind gbc_top gbc_top_properties chk (
   .sys_clk(sys_clk), .reset_n(reset_n), .atn_n(atn_n), .ren_n(ren_n),
   .ifc_n(ifc_n), .dio_n_in(dio_n_in), .byte_strb(byte_strb),
   .dio_oe(dio_oe), .dio_n_out(dio_n_out), .eoi_oe(eoi_oe), .srq_oe(srq_oe),
   .remote_led(remote_led), .talk_led(talk_led), .listen_led(listen_led),
   .recall_pulse(recall_pulse), .recall_loc(recall_loc),
   .standby_level(standby_level));

// ===== sim/gbc_top_tb.sv
// self-checking bench for the bus-command handler
`timescale 1ns/1ns
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin \
   err_count++; $display("[FAIL] %s exp %h got %h", n, e, g); end end
module gbc_top_tb;
   typedef struct packed {
      logic       c;
      logic [7:0] b;
      logic       t;
      logic       l;
      logic       r;
   } gbc_row_t;
   logic        sys_clk = 1'b0;
   logic        reset_n = 1'b0;
   logic [3:0]  reg_addr = 4'h0;
   logic [15:0] reg_wdata = 16'h0000;
   logic        reg_wr = 1'b0;
   logic        reg_rd = 1'b0;
   logic [15:0] reg_rdata, standby_level;
   logic        atn_n, ren_n, ifc_n, eoi_c, eoi_oe, srq_oe, dio_en, strb;
   logic        dio_oe, remote_led, talk_led, listen_led, recall_pulse;
   logic [7:0]  dio_drv, dio_out, dio_bus, recall_loc, st;
   logic        eoi_o, srq_o, eoi_bus, srq_bus;
   int          err_count = 0;
   int          checked = 0;
   gbc_row_t    rows [10] = '{'{1, 8'h2a, 0, 1, 0}, '{1, 8'h4a, 1, 0, 0},
      '{1, 8'h5f, 0, 0, 0}, '{1, 8'h2a, 0, 1, 0}, '{1, 8'h3f, 0, 0, 0},
      '{0, 8'h2a, 0, 0, 0}, '{0, 8'h14, 0, 0, 0}, '{1, 8'h2a, 0, 1, 0},
      '{1, 8'h4b, 0, 1, 0}, '{1, 8'h4a, 1, 0, 0}};
   // open-drain data lines: either side may pull low
   assign dio_bus = (dio_oe ? dio_out : 8'hff) & (dio_en ? dio_drv : 8'hff);
   assign eoi_bus = eoi_c & (eoi_oe ? eoi_o : 1'b1);
   assign srq_bus = srq_oe ? srq_o : 1'b1;
   always #2 sys_clk = ~sys_clk;
   gbc_top dut (
      .sys_clk(sys_clk), .reset_n(reset_n), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .atn_n(atn_n), .ren_n(ren_n), .ifc_n(ifc_n),
      .eoi_n_in(eoi_bus), .eoi_n_out(eoi_o), .eoi_oe(eoi_oe),
      .srq_n_out(srq_o), .srq_oe(srq_oe), .dio_n_in(dio_bus),
      .dio_n_out(dio_out), .dio_oe(dio_oe), .byte_strb(strb),
      .remote_led(remote_led), .talk_led(talk_led),
      .listen_led(listen_led), .recall_pulse(recall_pulse),
      .recall_loc(recall_loc), .standby_level(standby_level));
   gbc_ctl_model ctl (
      .sys_clk(sys_clk), .atn_n(atn_n), .ren_n(ren_n), .ifc_n(ifc_n),
      .eoi_n(eoi_c), .dio_drv_n(dio_drv), .dio_en(dio_en),
      .byte_strb(strb), .dio_bus_n(dio_bus));
   // ***
   // tasks
   // ***
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge sys_clk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge sys_clk);
      reg_wr    <= 1'b0;
      #1;
   endtask
   task automatic rdc(input logic [3:0] a, input logic [15:0] e);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge sys_clk);
      reg_rd   <= 1'b0;
      #1 `CHK("reg_rdata", e, reg_rdata)
   endtask
   task automatic poll(input logic [7:0] e);
      ctl.send(1'b1, 8'h18, 1'b0);
      ctl.send(1'b1, 8'h4a, 1'b0);
      ctl.talk_read(st);
      `CHK("dio_oe", 1'b1, dio_oe)
      `CHK("status", e, st)
      ctl.send(1'b1, 8'h19, 1'b0);
      ctl.talk_read(st);
      `CHK("dio_oe", 1'b0, dio_oe)
   endtask
   task automatic complete_run;
      $display("mismatches %0d of %0d checks", err_count, checked);
      if (err_count == 0 && checked > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   // ***
   // sequence
   // ***
   initial begin
      #40000;
      err_count++;
      complete_run();
   end
   initial begin
      repeat (6) @(posedge sys_clk);
      reset_n <= 1'b1;
      repeat (2) @(posedge sys_clk);
      rdc(gbc_pkg::OFS_CTRL, 16'h002a);
      rdc(gbc_pkg::OFS_SVC, 16'h0000);
      rdc(gbc_pkg::OFS_BUF_PTR, 16'h0001);
      wr(4'h9, 16'hffff);
      rdc(4'h9, 16'h0000);
      foreach (rows[i]) begin
         ctl.send(rows[i].c, rows[i].b, 1'b0);
         #1 `CHK("talk_led", rows[i].t, talk_led)
         `CHK("listen_led", rows[i].l, listen_led)
         `CHK("recall_pulse", rows[i].r, recall_pulse)
      end
      poll(8'h00);
      wr(gbc_pkg::OFS_SVC, 16'h0005);
      wr(gbc_pkg::OFS_CTRL, 16'h006a);
      `CHK("srq_oe", 1'b1, srq_oe)
      `CHK("srq_bus", 1'b0, srq_bus)
      poll(8'h45);
      wr(gbc_pkg::OFS_CTRL, 16'h002a);
      `CHK("srq_oe", 1'b0, srq_oe)
      `CHK("srq_bus", 1'b1, srq_bus)
      ctl.send(1'b1, 8'h2a, 1'b0);
      ctl.send(1'b0, 8'h5a, 1'b1);
      rdc(gbc_pkg::OFS_RX, 16'h035a);
      wr(gbc_pkg::OFS_CTRL, 16'h000a);
      ctl.send(1'b0, 8'h5b, 1'b1);
      rdc(gbc_pkg::OFS_RX, 16'h015b);
      wr(gbc_pkg::OFS_SETTINGS, 16'h1234);
      wr(gbc_pkg::OFS_BUF_PTR, 16'h0007);
      `CHK("standby_level", 16'h0000, standby_level)
      ctl.send(1'b1, 8'h14, 1'b0);
      #1 `CHK("recall_pulse", 1'b1, recall_pulse)
      `CHK("recall_loc", gbc_pkg::FIRST_LOCATION, recall_loc)
      `CHK("standby_level", gbc_pkg::STANDBY_COUNTS, standby_level)
      rdc(gbc_pkg::OFS_SETTINGS, {gbc_pkg::TERM_CR_LF,
         gbc_pkg::prefixed_output_format, gbc_pkg::standby_function_default,
         gbc_pkg::display_volts_amps_default});
      rdc(gbc_pkg::OFS_CTRL, 16'h002a);
      ctl.set_ren(1'b0);
      ctl.send(1'b1, 8'h4a, 1'b0);
      #1 `CHK("remote_led", 1'b1, remote_led)
      wr(gbc_pkg::OFS_TX, 16'h01a5);
      ctl.talk_read(st);
      `CHK("tx byte", 8'ha5, st)
      `CHK("eoi_oe", 1'b1, eoi_oe)
      `CHK("eoi_bus", 1'b0, eoi_bus)
      ctl.ifc_pulse();
      #1 `CHK("talk_led", 1'b0, talk_led)
      `CHK("remote_led", 1'b1, remote_led)
      rdc(gbc_pkg::OFS_STATE, 16'h0021);
      rdc(gbc_pkg::OFS_TX, 16'h01a5);
      rdc(gbc_pkg::OFS_EVENTS, 16'h0003);
      wr(gbc_pkg::OFS_EVENTS, 16'h0007);
      rdc(gbc_pkg::OFS_EVENTS, 16'h0000);
      ctl.set_ren(1'b1);
      repeat (2) @(posedge sys_clk);
      #1 `CHK("remote_led", 1'b0, remote_led)
      @(posedge sys_clk);
      reset_n <= 1'b0;
      repeat (3) @(posedge sys_clk);
      reset_n <= 1'b1;
      repeat (2) @(posedge sys_clk);
      rdc(gbc_pkg::OFS_SVC, 16'h0000);
      rdc(gbc_pkg::OFS_STATE, 16'h0000);
      complete_run();
   end
endmodule
